/* rtl/cqb_regs.vh */
`ifndef CQB_REGS_VH
`define CQB_REGS_VH

// register addresses, 7-bit space
`define CQB_ADDR_W            7
`define CQB_OFF_LINE_B_CTRL   7'h07
`define CQB_OFF_LINE_A_ERR    7'h08

// line_b_control field positions
`define CQB_RATE_HI           7
`define CQB_RATE_LO           6
`define CQB_AUTO_CONNECT      5
`define CQB_MANUAL_WAKE       4
`define CQB_TX_CLEAR          3
`define CQB_RX_CLEAR          2
`define CQB_TIMER_ARM         1
`define CQB_SEND              0

// line_a_error_flags field positions
`define CQB_SEND_FAULT_A      7

// reset values
`define CQB_CTRL_RESET        8'h00
`define CQB_ERR_RESET         8'h00
`define CQB_RATE_FAIL         2'h0

// serial frame: command byte, data byte
`define CQB_SPI_RW_BIT        7
`define CQB_SPI_LAST_CMD      5'h07
`define CQB_SPI_FIRST_DATA    5'h08
`define CQB_SPI_LAST_BIT      5'h0f

// timing: 80 us wake pulse at 10 MHz, detection timeout
`define CQB_WAKE_CYC          17'h00320
`define CQB_DETECT_WAIT_CYC   17'h0c350

`endif

/* rtl/cqb_spi_slave.v */
`timescale 1ns/1ps
`include "cqb_regs.vh"

// serial slave, mode 0, msb first: bit 7 of the command byte is 1 for read
module cqb_spi_slave (
    input  wire                    clk_in,    // core clock
    input  wire                    rst_in,    // synchronous reset
    input  wire                    sclk_in,   // serial clock pin
    input  wire                    cs_n_in,   // chip select pin, active low
    input  wire                    mosi_in,   // serial data in pin
    output wire                    miso_out,  // serial data out
    output reg  [`CQB_ADDR_W-1:0]  addr_out,  // register address of the frame
    output reg  [7:0]              wdata_out, // write data
    output reg                     wr_out,    // write strobe, one cycle
    output reg                     rd_out,    // read strobe, one cycle
    input  wire [7:0]              rdata_in   // read data for addr_out
);
    reg        sclk_s1, sclk_s2, sclk_s3; // clock synchroniser and edge stage
    reg        cs_s1, cs_s2;              // select synchroniser
    reg        mosi_s1, mosi_s2;          // data synchroniser
    reg [4:0]  cnt_q;                     // bits taken in this frame
    reg [6:0]  sh_q;                      // input shift register
    reg [7:0]  tx_q;                      // output shift register
    reg        rw_q;                      // 1 when the frame is a read
    wire       rise;                      // serial clock rising edge
    wire       fall;                      // serial clock falling edge

    assign rise     = sclk_s2 & ~sclk_s3;
    assign fall     = ~sclk_s2 & sclk_s3;
    assign miso_out = tx_q[7];

    // pin synchronisers, second stage feeds the logic
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            cs_s1   <= 1'b1;
            cs_s2   <= 1'b1;
            mosi_s1 <= 1'b0;
            mosi_s2 <= 1'b0;
        end
        else
        begin
            sclk_s1 <= sclk_in;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            cs_s1   <= cs_n_in;
            cs_s2   <= cs_s1;
            mosi_s1 <= mosi_in;
            mosi_s2 <= mosi_s1;
        end
    end

    // frame decoder and shifter
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            cnt_q     <= 5'h00;
            sh_q      <= 7'h00;
            tx_q      <= 8'h00;
            rw_q      <= 1'b0;
            addr_out  <= {`CQB_ADDR_W{1'b0}};
            wdata_out <= 8'h00;
            wr_out    <= 1'b0;
            rd_out    <= 1'b0;
        end
        else
        begin
            wr_out <= 1'b0;
            rd_out <= 1'b0;
            if (cs_s2)
            begin
                // deselected: frame aborted, output idles low
                cnt_q <= 5'h00;
                tx_q  <= 8'h00;
            end
            else if (rd_out)
                // load read data before clear-on-read lands
                tx_q <= rdata_in;
            else if (rise)
            begin
                sh_q  <= {sh_q[5:0], mosi_s2};
                cnt_q <= cnt_q + 5'h01;
                if (cnt_q == `CQB_SPI_LAST_CMD)
                begin
                    // command byte complete
                    rw_q     <= sh_q[6];
                    addr_out <= {sh_q[5:0], mosi_s2};
                    rd_out   <= sh_q[6];
                end
                else if ((cnt_q == `CQB_SPI_LAST_BIT) && !rw_q)
                begin
                    // data byte complete on a write
                    wdata_out <= {sh_q, mosi_s2};
                    wr_out    <= 1'b1;
                end
            end
            else if (fall && (cnt_q > `CQB_SPI_FIRST_DATA))
                // bit 7 shown at load, shift the rest
                tx_q <= {tx_q[6:0], 1'b0};
        end
    end
endmodule // cqb_spi_slave

/* rtl/cqb_line_ctrl.v */
// Function
// [RULE_01] successful connect stores detected rate code
// [RULE_02] auto connect bit starts wake and detection
// [RULE_03] boost current limit during wake, config unchanged
// [RULE_04] failed connect: irq, clear bit, rate zero
// [RULE_05] host enables frame engine before auto connect
// [RULE_06] success captures field period for reading
// [RULE_07] manual wake bit sends wake pulse now
// [RULE_08] after manual wake, transceiver to receive
// [RULE_09] manual wake bit self clears when done
// [RULE_10] manual wake serves host-run connect sequences
// [RULE_11] tx clear bit empties transmit queue
// [RULE_12] rx clear bit empties receive queue
// [RULE_13] timer arm bit arms, does not start
// [RULE_14] armed timer starts on send or trigger
// [RULE_15] clearing arm stops timer at once
// [RULE_16] send bit: transmit mode, send queued message
// [RULE_17] message done and queue empty: receive mode
// [RULE_18] send bit clears itself automatically
// [RULE_19] line a send fault sets error flag
// [RULE_20] reading line a error register clears flag
`timescale 1ns/1ps
`include "cqb_regs.vh"

module cqb_line_ctrl #(
    parameter [16:0] DETECT_WAIT_CYC = `CQB_DETECT_WAIT_CYC // rate detection timeout
) (
    input  wire        CORE_CLK_IN,        // core clock, 10 MHz
    input  wire        RST_IN,             // synchronous reset, active high
    input  wire        SPI_SCLK_IN,        // serial clock from host
    input  wire        SPI_CS_N_IN,        // serial select from host, active low
    input  wire        SPI_MOSI_IN,        // serial data from host
    output wire        SPI_MISO_OUT,       // serial data to host
    input  wire        RATE_DONE_IN,       // detector found a rate, pulse
    input  wire        RATE_FAIL_IN,       // detector gave up, pulse
    input  wire [1:0]  RATE_CODE_IN,       // detected rate code
    input  wire [7:0]  FIELD_PERIOD_IN,    // field device cycle time from detector
    input  wire        TX_MSG_DONE_IN,     // framer finished the master message
    input  wire        TX_QUEUE_EMPTY_IN,  // transmit queue holds no data
    input  wire        TIMER_TRIGGER_IN,   // trigger command for the cycle timer
    input  wire        SEND_FAULT_A_IN,    // line a message not sent properly, pulse
    output reg         LINE_B_TX_EN_OUT,   // 1 transmit mode, 0 receive mode
    output reg         LINE_B_WAKE_OUT,    // wake-up pulse being driven
    output reg         CURRENT_BOOST_OUT,  // internal current limit raised
    output reg         WAKE_DONE_IRQ_OUT,  // wake_done_irq event, pulse
    output reg         TX_QUEUE_CLEAR_OUT, // empty tx_queue_b, pulse
    output reg         RX_QUEUE_CLEAR_OUT, // empty rx_queue, pulse
    output reg         SEND_START_OUT,     // framer starts the message, pulse
    output reg         TIMER_RUN_OUT,      // cycle timer counting
    output reg  [7:0]  FIELD_PERIOD_B_OUT  // field_period_b register contents
);
    // sequencer states
    localparam [1:0] ST_IDLE   = 2'h0; // nothing running
    localparam [1:0] ST_WAKE   = 2'h1; // driving the wake-up pulse
    localparam [1:0] ST_DETECT = 2'h2; // waiting for rate detection
    localparam [1:0] ST_SEND   = 2'h3; // master message on the line

    localparam [16:0] WAKE_CYC = `CQB_WAKE_CYC; // wake pulse length in cycles

    wire [`CQB_ADDR_W-1:0] addr;      // frame address from serial slave
    wire [7:0]             wdata;     // frame write data
    wire                   wr;        // write strobe
    wire                   rd;        // read strobe
    reg  [7:0]             rdata;     // read mux

    reg  [7:0]  ctrl_q, ctrl_d;       // line_b_control
    reg  [7:0]  err_q, err_d;         // line_a_error_flags
    reg  [1:0]  st_q, st_d;           // sequencer state
    reg  [16:0] cnt_q, cnt_d;         // wake and timeout counter
    reg         auto_q, auto_d;       // current wake belongs to auto connect

    wire wr_ctrl;                     // write to line_b_control
    wire rd_err;                      // read of line_a_error_flags

    // address match shared by read and write decode
    function hit;
        input [`CQB_ADDR_W-1:0] a;
        input [`CQB_ADDR_W-1:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    assign wr_ctrl = wr & hit(addr, `CQB_OFF_LINE_B_CTRL);
    assign rd_err  = rd & hit(addr, `CQB_OFF_LINE_A_ERR);

    // host serial port
    cqb_spi_slave u_spi (
        .clk_in    (CORE_CLK_IN),
        .rst_in    (RST_IN),
        .sclk_in   (SPI_SCLK_IN),
        .cs_n_in   (SPI_CS_N_IN),
        .mosi_in   (SPI_MOSI_IN),
        .miso_out  (SPI_MISO_OUT),
        .addr_out  (addr),
        .wdata_out (wdata),
        .wr_out    (wr),
        .rd_out    (rd),
        .rdata_in  (rdata)
    );

    // read mux, unmapped addresses read zero
    always @*
    begin
        if (hit(addr, `CQB_OFF_LINE_B_CTRL))
            rdata = ctrl_q;
        else if (hit(addr, `CQB_OFF_LINE_A_ERR))
            rdata = err_q;
        else
            rdata = 8'h00;
    end

    // error flags: set wins over clear-on-read
    always @*
    begin
        err_d = err_q;
        // [RULE_20] clear on read
        if (rd_err)
            err_d = `CQB_ERR_RESET;
        // [RULE_19] flag send fault
        if (SEND_FAULT_A_IN)
            err_d[`CQB_SEND_FAULT_A] = 1'b1;
    end

    // control register and sequencer next state
    always @*
    begin
        ctrl_d = ctrl_q;
        st_d   = st_q;
        cnt_d  = cnt_q;
        auto_d = auto_q;
        // queue clear bits are one-shot
        ctrl_d[`CQB_TX_CLEAR] = 1'b0;
        ctrl_d[`CQB_RX_CLEAR] = 1'b0;
        if (wr_ctrl)
        begin
            // rate and arm bits: host storage
            ctrl_d[`CQB_RATE_HI:`CQB_RATE_LO] = wdata[`CQB_RATE_HI:`CQB_RATE_LO];
            ctrl_d[`CQB_TIMER_ARM] = wdata[`CQB_TIMER_ARM];
            // [RULE_11] empty transmit queue
            ctrl_d[`CQB_TX_CLEAR] = wdata[`CQB_TX_CLEAR];
            // [RULE_12] empty receive queue
            ctrl_d[`CQB_RX_CLEAR] = wdata[`CQB_RX_CLEAR];
        end
        case (st_q)
            ST_IDLE:
            begin
                cnt_d = 17'h00000;
                if (wr_ctrl && wdata[`CQB_AUTO_CONNECT])
                begin
                    // [RULE_02] start auto connect; relies on frame engine on
                    ctrl_d[`CQB_AUTO_CONNECT] = 1'b1;
                    auto_d = 1'b1;
                    st_d   = ST_WAKE;
                end
                else if (wr_ctrl && wdata[`CQB_MANUAL_WAKE])
                begin
                    // [RULE_07] wake pulse at once, no detection
                    ctrl_d[`CQB_MANUAL_WAKE] = 1'b1;
                    auto_d = 1'b0;
                    st_d   = ST_WAKE;
                end
                else if (wr_ctrl && wdata[`CQB_SEND])
                begin
                    // [RULE_16] start master message
                    ctrl_d[`CQB_SEND] = 1'b1;
                    st_d = ST_SEND;
                end
            end
            ST_WAKE:
            begin
                cnt_d = cnt_q + 17'h00001;
                if (cnt_q == WAKE_CYC - 17'h00001)
                begin
                    cnt_d = 17'h00000;
                    if (auto_q)
                        st_d = ST_DETECT;
                    else
                    begin
                        // [RULE_09] manual wake bit self clears
                        ctrl_d[`CQB_MANUAL_WAKE] = 1'b0;
                        st_d = ST_IDLE;
                    end
                end
            end
            ST_DETECT:
            begin
                cnt_d = cnt_q + 17'h00001;
                if (RATE_DONE_IN)
                begin
                    // [RULE_01] store detected rate
                    ctrl_d[`CQB_RATE_HI:`CQB_RATE_LO] = RATE_CODE_IN;
                    ctrl_d[`CQB_AUTO_CONNECT] = 1'b0;
                    st_d = ST_IDLE;
                end
                else if (RATE_FAIL_IN || (cnt_q == DETECT_WAIT_CYC - 17'h00001))
                begin
                    // [RULE_04] failure forces rate to zero
                    ctrl_d[`CQB_RATE_HI:`CQB_RATE_LO] = `CQB_RATE_FAIL;
                    ctrl_d[`CQB_AUTO_CONNECT] = 1'b0;
                    st_d = ST_IDLE;
                end
            end
            ST_SEND:
            begin
                // [RULE_17] back to receive when done and empty
                if (TX_MSG_DONE_IN && TX_QUEUE_EMPTY_IN)
                begin
                    // [RULE_18] send bit self clears
                    ctrl_d[`CQB_SEND] = 1'b0;
                    st_d = ST_IDLE;
                end
            end
            default:
                st_d = ST_IDLE;
        endcase
    end

    // state registers
    always @(posedge CORE_CLK_IN)
    begin
        if (RST_IN)
        begin
            ctrl_q <= `CQB_CTRL_RESET;
            err_q  <= `CQB_ERR_RESET;
            st_q   <= ST_IDLE;
            cnt_q  <= 17'h00000;
            auto_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            err_q  <= err_d;
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            auto_q <= auto_d;
        end
    end

    // line, timer and event outputs, each from a flip-flop
    always @(posedge CORE_CLK_IN)
    begin
        if (RST_IN)
        begin
            LINE_B_TX_EN_OUT   <= 1'b0;
            LINE_B_WAKE_OUT    <= 1'b0;
            CURRENT_BOOST_OUT  <= 1'b0;
            WAKE_DONE_IRQ_OUT  <= 1'b0;
            TX_QUEUE_CLEAR_OUT <= 1'b0;
            RX_QUEUE_CLEAR_OUT <= 1'b0;
            SEND_START_OUT     <= 1'b0;
            TIMER_RUN_OUT      <= 1'b0;
            FIELD_PERIOD_B_OUT <= 8'h00;
        end
        else
        begin
            // [RULE_08] transmit only while waking or sending
            LINE_B_TX_EN_OUT <= (st_d == ST_WAKE) || (st_d == ST_SEND);
            LINE_B_WAKE_OUT  <= (st_d == ST_WAKE);
            // [RULE_03] boost only during an auto connect wake pulse
            CURRENT_BOOST_OUT <= (st_d == ST_WAKE) && auto_d;
            // [RULE_02] event when the detect phase ends, on success or on failure
            WAKE_DONE_IRQ_OUT <= (st_q == ST_DETECT) && (st_d == ST_IDLE);
            TX_QUEUE_CLEAR_OUT <= ctrl_d[`CQB_TX_CLEAR];
            RX_QUEUE_CLEAR_OUT <= ctrl_d[`CQB_RX_CLEAR];
            SEND_START_OUT <= (st_q == ST_IDLE) && (st_d == ST_SEND);
            // [RULE_06] capture field period on success
            if ((st_q == ST_DETECT) && RATE_DONE_IN)
                FIELD_PERIOD_B_OUT <= FIELD_PERIOD_IN;
            // [RULE_15] disarm stops the timer at once
            if (!ctrl_d[`CQB_TIMER_ARM])
                TIMER_RUN_OUT <= 1'b0;
            // [RULE_14] armed timer starts on send or trigger
            else if (SEND_START_OUT || TIMER_TRIGGER_IN)
                TIMER_RUN_OUT <= 1'b1;
            // [RULE_13] arming alone leaves the timer as it was
        end
    end
endmodule // cqb_line_ctrl

/* test/cqb_line_checker.sv */
`timescale 1ns/1ps
`include "cqb_regs.vh"

// watches line b sequencing at the top ports
module cqb_line_checker #(
    parameter [16:0] DETECT_WAIT_CYC = 17'h0c350 // detection timeout
) (
    input wire       CORE_CLK_IN,
    input wire       RST_IN,
    input wire       RATE_DONE_IN,
    input wire       RATE_FAIL_IN,
    input wire [7:0] FIELD_PERIOD_IN,
    input wire       TX_MSG_DONE_IN,
    input wire       TX_QUEUE_EMPTY_IN,
    input wire       TIMER_TRIGGER_IN,
    input wire       LINE_B_TX_EN_OUT,
    input wire       LINE_B_WAKE_OUT,
    input wire       CURRENT_BOOST_OUT,
    input wire       WAKE_DONE_IRQ_OUT,
    input wire       TX_QUEUE_CLEAR_OUT,
    input wire       RX_QUEUE_CLEAR_OUT,
    input wire       SEND_START_OUT,
    input wire       TIMER_RUN_OUT,
    input wire [7:0] FIELD_PERIOD_B_OUT
);
    reg     boost_q;    // boost one cycle back
    reg     det_q;      // waiting for a rate
    integer det_cnt_q;  // cycles spent waiting
    integer wake_cnt_q; // cycles the wake pulse stood

    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);

    // wake length and detect phase
    always @(posedge CORE_CLK_IN)
    begin
        if (RST_IN)
        begin
            boost_q    <= 1'b0;
            det_q      <= 1'b0;
            det_cnt_q  <= 0;
            wake_cnt_q <= 0;
        end
        else
        begin
            boost_q    <= CURRENT_BOOST_OUT;
            wake_cnt_q <= LINE_B_WAKE_OUT ? wake_cnt_q + 1 : 0;
            det_cnt_q  <= det_q ? det_cnt_q + 1 : 0;
            if (WAKE_DONE_IRQ_OUT)
                det_q <= 1'b0; // sequence over
            else if (boost_q && !CURRENT_BOOST_OUT)
                det_q <= 1'b1; // auto pulse just ended
        end
    end

    a_boost_needs_wake: assert property (CURRENT_BOOST_OUT |-> LINE_B_WAKE_OUT)
        else $error("boost alone");
    a_wake_length: assert property ($fell(LINE_B_WAKE_OUT) |-> wake_cnt_q == `CQB_WAKE_CYC)
        else $error("wake length");
    a_result_irq: assert property (det_q && (RATE_DONE_IN || RATE_FAIL_IN) |=> WAKE_DONE_IRQ_OUT)
        else $error("no irq");
    a_fail_timeout: assert property (det_cnt_q <= DETECT_WAIT_CYC + 2)
        else $error("detect too long");
    a_period_capture: assert property (det_q && RATE_DONE_IN |=>
        FIELD_PERIOD_B_OUT == $past(FIELD_PERIOD_IN))
        else $error("period lost");
    a_rx_after_wake: assert property ($fell(LINE_B_WAKE_OUT) |-> !LINE_B_TX_EN_OUT)
        else $error("tx after wake");
    a_send_tx_mode: assert property (SEND_START_OUT |=> LINE_B_TX_EN_OUT)
        else $error("send not tx");
    a_msg_done_rx: assert property (LINE_B_TX_EN_OUT && !LINE_B_WAKE_OUT && TX_MSG_DONE_IN
        && TX_QUEUE_EMPTY_IN |=> !LINE_B_TX_EN_OUT)
        else $error("tx after done");
    a_tx_hold_busy: assert property ($fell(LINE_B_TX_EN_OUT) && !$past(LINE_B_WAKE_OUT) |->
        $past(TX_MSG_DONE_IN) && $past(TX_QUEUE_EMPTY_IN))
        else $error("tx left early");
    a_timer_cause: assert property ($rose(TIMER_RUN_OUT) |->
        $past(TIMER_TRIGGER_IN) || $past(SEND_START_OUT))
        else $error("timer no cause");
    a_clear_pulse: assert property ((TX_QUEUE_CLEAR_OUT || RX_QUEUE_CLEAR_OUT) |=>
        !TX_QUEUE_CLEAR_OUT && !RX_QUEUE_CLEAR_OUT)
        else $error("clear too long");
endmodule // cqb_line_checker

/* test/cqb_field_model.sv */
`timescale 1ns/1ps

// field device and framer stand-in
module cqb_field_model (
    input  wire       clk_in,        // core clock
    input  wire       rst_in,        // synchronous reset
    input  wire       boost_in,      // auto wake pulse
    input  wire       send_start_in, // master message starts
    input  wire [1:0] mode_in,       // 0 answer, 1 refuse, 2 silent
    input  wire [1:0] code_in,       // rate to report
    input  wire [7:0] per_in,        // cycle time to report
    input  wire [7:0] lag_in,        // reply delay in cycles
    output reg        rate_done_out, // rate found, pulse
    output reg        rate_fail_out, // rate not found, pulse
    output reg  [1:0] rate_code_out, // rate code
    output reg  [7:0] period_out,    // cycle time
    output reg        msg_done_out,  // message finished
    output reg        q_empty_out    // queue empty
);
    reg       auto_q; // wake answer due
    reg       send_q; // message on the wire
    reg [7:0] wait_q; // cycles left

    // data lines drift while not valid
    always @(posedge clk_in)
    begin
        rate_done_out <= 1'b0;
        rate_fail_out <= 1'b0;
        msg_done_out  <= 1'b0;
        rate_code_out <= ~rate_code_out;
        period_out    <= period_out + 8'h35;
        if (rst_in)
        begin
            auto_q        <= 1'b0;
            send_q        <= 1'b0;
            wait_q        <= 8'h00;
            q_empty_out   <= 1'b1;
            rate_code_out <= 2'h0;
            period_out    <= 8'h00;
        end
        else if (boost_in)
        begin
            auto_q <= 1'b1; // answer after the pulse
            wait_q <= lag_in;
        end
        else if (auto_q)
        begin
            wait_q <= wait_q - 8'h01;
            if (wait_q == 8'h00)
            begin
                auto_q        <= 1'b0;
                rate_done_out <= (mode_in == 2'h0);
                rate_fail_out <= (mode_in == 2'h1);
                rate_code_out <= code_in;
                period_out    <= per_in;
            end
        end
        else if (send_start_in)
        begin
            send_q      <= 1'b1;
            wait_q      <= lag_in;
            q_empty_out <= 1'b0;
        end
        else if (send_q)
        begin
            wait_q       <= wait_q - 8'h01;
            // early done, queue not empty
            msg_done_out <= (wait_q == 8'h02) || (wait_q == 8'h00);
            if (wait_q == 8'h00)
            begin
                send_q      <= 1'b0;
                q_empty_out <= 1'b1;
            end
        end
    end
endmodule // cqb_field_model

/* test/testbench.sv */
`timescale 1ns/1ps

// serial host, partner and checks
module testbench;
    reg        clk = 1'b0, rst = 1'b1; // core clock, reset
    reg        sclk = 1'b0, cs_n = 1'b1, mosi = 1'b0; // serial pins
    reg        trig = 1'b0, fault = 1'b0; // timer trigger, line a fault
    reg  [1:0] m_mode = 2'h0, m_code = 2'h1; // partner mode, rate
    reg  [7:0] m_per = 8'h00, m_lag = 8'h04; // partner period, delay
    reg  [7:0] rd; // read data
    reg [31:0] r; // random word
    integer    seed, i;
    integer    n_mismatch = 0;
    integer    comparisons = 0;
    integer    n_irq = 0, n_clr = 0; // pulses seen
    wire       miso, done, fail, mdone, qe, txen, wake, boost, irq, txc, rxc, start, run;
    wire [1:0] code;
    wire [7:0] per, fp;

    always #50 clk = ~clk;

    // count one-cycle pulses
    always @(posedge clk)
    begin
        n_irq <= n_irq + (irq === 1'b1);
        n_clr <= n_clr + (txc === 1'b1) + (rxc === 1'b1);
    end

    cqb_line_ctrl #(.DETECT_WAIT_CYC(17'h00032)) dut_u (
        .CORE_CLK_IN(clk), .RST_IN(rst), .SPI_SCLK_IN(sclk), .SPI_CS_N_IN(cs_n),
        .SPI_MOSI_IN(mosi), .SPI_MISO_OUT(miso), .RATE_DONE_IN(done), .RATE_FAIL_IN(fail),
        .RATE_CODE_IN(code), .FIELD_PERIOD_IN(per), .TX_MSG_DONE_IN(mdone),
        .TX_QUEUE_EMPTY_IN(qe), .TIMER_TRIGGER_IN(trig), .SEND_FAULT_A_IN(fault),
        .LINE_B_TX_EN_OUT(txen), .LINE_B_WAKE_OUT(wake), .CURRENT_BOOST_OUT(boost),
        .WAKE_DONE_IRQ_OUT(irq), .TX_QUEUE_CLEAR_OUT(txc), .RX_QUEUE_CLEAR_OUT(rxc),
        .SEND_START_OUT(start), .TIMER_RUN_OUT(run), .FIELD_PERIOD_B_OUT(fp));

    cqb_field_model model_u (
        .clk_in(clk), .rst_in(rst), .boost_in(boost), .send_start_in(start),
        .mode_in(m_mode), .code_in(m_code), .per_in(m_per), .lag_in(m_lag),
        .rate_done_out(done), .rate_fail_out(fail), .rate_code_out(code),
        .period_out(per), .msg_done_out(mdone), .q_empty_out(qe));

    // expected control value
    function [7:0] exp_ctrl(input [1:0] rate, input arm);
        exp_ctrl = {rate, 4'h0, arm, 1'b0};
    endfunction

    task cyc(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask

    task finish_test;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
            if (n_mismatch == 0 && comparisons > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    task check(input [8*8-1:0] what, input [7:0] got, input [7:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp)
            begin
                n_mismatch = n_mismatch + 1;
                $display("[ERR] %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    // one 16-bit frame, read byte into rd
    task spi(input [7:0] cmd, input [7:0] din);
        reg [15:0] s;
        integer    b;
        begin
            s = {cmd, din};
            rd = 8'h00;
            cs_n = 1'b0;
            for (b = 15; b >= 0; b = b - 1)
            begin
                mosi = s[b];
                cyc(5);
                rd = {rd[6:0], miso};
                sclk = 1'b1;
                cyc(5);
                sclk = 1'b0;
            end
            cyc(6);
            cs_n = 1'b1;
            cyc(4);
        end
    endtask

    // bounded wait: 0 irq, 1 wake low, 2 transmit off
    task wait_sig(input integer sel);
        integer n;
        begin
            n = 0;
            while (!((sel == 0 && irq === 1'b1) || (sel == 1 && wake === 1'b0)
                   || (sel == 2 && txen === 1'b0)) && n < 2000)
            begin
                cyc(1);
                n = n + 1;
            end
            if (n >= 2000)
            begin
                n_mismatch = n_mismatch + 1;
                $display("[ERR] wait %0d timed out", sel);
                finish_test;
            end
        end
    endtask

    initial
    begin
        seed = 63622;
        cyc(3);
        rst = 1'b0;
        cyc(3);
        spi(8'h87, 8'h00);
        check("ctrl", rd, 8'h00);
        spi(8'h88, 8'h00);
        check("err", rd, 8'h00);
        spi(8'h15, 8'hff);
        spi(8'h95, 8'h00);
        check("unmapped", rd, 8'h00);
        $display("reset test done");
        for (i = 1; i < 4; i = i + 1)
        begin
            r = $random(seed);
            m_code = i[1:0];
            m_per = r[7:0];
            m_lag = {4'h0, r[11:8]} + 8'h03;
            spi(8'h07, 8'h20);
            check("boost", {7'h00, boost}, 8'h01);
            wait_sig(0);
            check("period", fp, m_per);
            spi(8'h87, 8'h00);
            check("rate", rd, exp_ctrl(m_code, 1'b0));
        end
        for (i = 1; i < 3; i = i + 1)
        begin
            m_mode = i[1:0];
            spi(8'h07, 8'he0);
            wait_sig(0);
            spi(8'h87, 8'h00);
            check("fail", rd, exp_ctrl(2'h0, 1'b0));
        end
        $display("connect test done");
        spi(8'h07, 8'h10);
        check("wake", {6'h00, wake, boost}, 8'h02);
        wait_sig(1);
        check("txen", {7'h00, txen}, 8'h00);
        spi(8'h87, 8'h00);
        check("manual", rd, 8'h00);
        check("irqs", n_irq[7:0], 8'h05);
        spi(8'h07, 8'h0c);
        spi(8'h87, 8'h00);
        check("clears", n_clr[7:0], 8'h02);
        check("clrbits", rd, 8'h00);
        spi(8'h07, 8'h02);
        check("armed", {7'h00, run}, 8'h00);
        trig = 1'b1;
        cyc(1);
        trig = 1'b0;
        cyc(1);
        check("trig", {7'h00, run}, 8'h01);
        spi(8'h07, 8'h00);
        check("stop", {7'h00, run}, 8'h00);
        $display("wake timer test done");
        for (i = 0; i < 4; i = i + 1)
        begin
            r = $random(seed);
            m_lag = 8'hd0 + {3'h0, r[4:0]};
            spi(8'h07, exp_ctrl(2'h0, i[0]) | 8'h01);
            check("send", {6'h00, txen, run}, {7'h01, i[0]});
            spi(8'h87, 8'h00);
            check("busy", rd, exp_ctrl(2'h0, i[0]) | 8'h01);
            wait_sig(2);
            spi(8'h87, 8'h00);
            check("sent", rd, exp_ctrl(2'h0, i[0]));
        end
        $display("send test done");
        fault = 1'b1;
        cyc(1);
        fault = 1'b0;
        cyc(1);
        spi(8'h88, 8'h00);
        check("errset", rd, 8'h80);
        spi(8'h88, 8'h00);
        check("errclr", rd, 8'h00);
        $display("error test done");
        finish_test;
    end
endmodule // testbench

bind cqb_line_ctrl cqb_line_checker #(.DETECT_WAIT_CYC(DETECT_WAIT_CYC)) chk_u (.*);
